// ---- common/reset_seq_pkg.sv ----
// Constants and types shared by the reset and power-up sequencer
package reset_seq_pkg;

  // System clock rate
  localparam int unsigned REF_CLK_HZ      = 20_000_000;
  // Nominal power-up delay, in microseconds
  localparam int unsigned POWER_UP_DELAY_TIMER_TIME_US    = 96_000;
  // Default rate of the internal RC oscillator that times the delay
  localparam int unsigned RC_OSC_KHZ_DFLT = 20;
  // RC oscillator edges in one power-up delay
  localparam int unsigned POWER_UP_DELAY_TIMER_TICKS_DFLT = POWER_UP_DELAY_TIMER_TIME_US * RC_OSC_KHZ_DFLT / 1000;

  // Reset values of the status flags and strobes
  localparam logic TO_RST_VAL  = 1'h1;
  localparam logic PD_RST_VAL  = 1'h1;
  localparam logic ALE_PARK    = 1'h0;
  localparam logic RD_N_PARK   = 1'h1;
  localparam logic WR_N_PARK   = 1'h1;

  // One-hot instruction phases; the first phase is bit 0
  localparam logic [3:0] PHASE_FIRST = 4'h1;

  typedef enum logic [4:0] {
    S_POWER_ON  = 5'h01,
    S_PIN_WAIT  = 5'h02,
    S_POWER_UP_DELAY_TIMER      = 5'h04,
    S_RUN       = 5'h08,
    S_HELD      = 5'h10
  } seq_state_e;

  typedef struct packed {
    logic ale;
    logic rd_n;
    logic wr_n;
  } bus_strobe_s;

  typedef struct packed {
    logic power_on;
    logic master_clear;
    logic watchdog;
  } reset_cause_s;

  typedef struct packed {
    logic timeout_flag;
    logic powerdown_flag;
  } status_flags_s;

endpackage

// ---- rtl/reset_and_powerup_sequencer.sv ----
// Reset source merging, power-up delay, phase freeze and bus strobe parking
`timescale 1ns/100ps
`default_nettype none

// Function
// - Power-on, master clear and watchdog resets are told apart as three sources.
// - The retained register group gets no reset signal from any source.
// - Resettable registers are reset on power-on, master clear, running watchdog and sleep master clear.
// - A watchdog expiry during sleep only wakes the core and resets no register.
// - Timeout and powerdown flags are set or cleared per reset situation to show the cause.
// - The four-phase clock sequencer is held in its first phase during any reset.
// - In external execution modes reset drives address latch low and read and write high.
// - Power-on reset holds until the supply monitor reports the trip threshold crossed.
// - A falling supply also resets unless the part is built to reset on rising supply only.
// - The power-up delay of nominally 96 ms starts once supply is good and the pin is high.
// - Reset stays asserted while the power-up delay counts.
// - The power-up delay counts edges of the separate internal RC oscillator.
// - A master clear reset leaves the timeout and powerdown flags as they were.
module reset_and_powerup_sequencer
  import reset_seq_pkg::*;
#(
  parameter int unsigned POWER_UP_DELAY_TIMER_TICKS         = POWER_UP_DELAY_TIMER_TICKS_DFLT,
  parameter bit          FALLING_SUPPLY_RST = 1'b1
)(
  input  wire logic          ref_clk,
  input  wire logic          rst,
  input  wire logic          master_clear_pin_n,
  input  wire logic          supply_above_trip,
  input  wire logic          rc_osc_clk,
  input  wire logic          watchdog_expiry_reset,
  input  wire logic          sleep_mode,
  input  wire logic          sleep_enter,
  input  wire logic          watchdog_clear,
  input  wire logic          ext_exec_mode,
  input  wire bus_strobe_s   core_bus_out,
  input  wire bus_strobe_s   core_bus_oe,
  output logic               core_reset_ff,
  output logic               reg_reset_ff,
  output logic               wake_pulse_ff,
  output logic [3:0]         phase_ff,
  output status_flags_s      flags_ff,
  output reset_cause_s       cause_ff,
  output bus_strobe_s        bus_out_ff,
  output bus_strobe_s        bus_oe_ff
);

  localparam int unsigned CW = $clog2(POWER_UP_DELAY_TIMER_TICKS + 1);
  localparam logic [CW-1:0] LAST_TICK = CW'(POWER_UP_DELAY_TIMER_TICKS - 1);

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic master_clear_pin_meta_ff;
  logic master_clear_pin_sync_ff;
  logic sup_meta_ff;
  logic sup_sync_ff;
  logic rc_meta_ff;
  logic rc_sync_ff;
  logic rc_prev_ff;

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      master_clear_pin_meta_ff <= 1'h0;
      master_clear_pin_sync_ff <= 1'h0;
      sup_meta_ff  <= 1'h0;
      sup_sync_ff  <= 1'h0;
      rc_meta_ff   <= 1'h0;
      rc_sync_ff   <= 1'h0;
      rc_prev_ff   <= 1'h0;
    end
    else
    begin
      master_clear_pin_meta_ff <= master_clear_pin_n;
      master_clear_pin_sync_ff <= master_clear_pin_meta_ff;
      sup_meta_ff  <= supply_above_trip;
      sup_sync_ff  <= sup_meta_ff;
      rc_meta_ff   <= rc_osc_clk;
      rc_sync_ff   <= rc_meta_ff;
      rc_prev_ff   <= rc_sync_ff;
    end
  end

  logic rc_tick;
  logic master_clear_pin_low;
  logic supply_lost;

  // Only the second stage and later are looked at
  assign rc_tick     = rc_sync_ff & ~rc_prev_ff;
  assign master_clear_pin_low    = ~master_clear_pin_sync_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencer state and power-up delay counter

  seq_state_e    state_ff;
  seq_state_e    nxt_state;
  logic [CW-1:0] cnt_ff;
  logic [CW-1:0] nxt_cnt;
  logic          powered_ff;
  logic          nxt_powered;

  // A part built for rising-supply reset only ignores a later dip
  assign supply_lost = ~sup_sync_ff & (FALLING_SUPPLY_RST | ~powered_ff);

  always_comb
  begin
    nxt_state   = state_ff;
    nxt_cnt     = cnt_ff;
    nxt_powered = powered_ff;
    if (supply_lost)
    begin
      nxt_state = S_POWER_ON;
      nxt_cnt   = '0;
    end
    else
    begin
      unique case (state_ff)
        S_POWER_ON:
        begin
          nxt_powered = 1'h1;
          nxt_state   = S_PIN_WAIT;
        end
        S_PIN_WAIT:
        begin
          nxt_cnt = '0;
          if (master_clear_pin_sync_ff)
            nxt_state = S_POWER_UP_DELAY_TIMER;
        end
        S_POWER_UP_DELAY_TIMER:
        begin
          // Pulling the pin low restarts the whole delay
          if (master_clear_pin_low)
          begin
            nxt_state = S_PIN_WAIT;
            nxt_cnt   = '0;
          end
          else if (rc_tick && cnt_ff == LAST_TICK)
            nxt_state = S_RUN;
          else if (rc_tick)
            nxt_cnt = cnt_ff + CW'(1);
        end
        S_RUN:
        begin
          if (master_clear_pin_low)
            nxt_state = S_HELD;
          else if (watchdog_expiry_reset && !sleep_mode)
            nxt_state = S_HELD;
        end
        S_HELD:
        begin
          if (!master_clear_pin_low && !watchdog_expiry_reset)
            nxt_state = S_RUN;
        end
        default:
          nxt_state = S_POWER_ON;
      endcase
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      state_ff   <= S_POWER_ON;
      cnt_ff     <= '0;
      powered_ff <= 1'h0;
    end
    else
    begin
      state_ff   <= nxt_state;
      cnt_ff     <= nxt_cnt;
      powered_ff <= nxt_powered;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Reset outputs, wake and cause

  logic         wdt_run;
  logic         wdt_sleep;
  logic         in_reset;
  logic         nxt_core_reset;
  logic         nxt_reg_reset;
  logic         nxt_wake;
  reset_cause_s nxt_cause;

  assign wdt_run   = state_ff == S_RUN && watchdog_expiry_reset && !sleep_mode && !master_clear_pin_low;
  assign wdt_sleep = state_ff == S_RUN && watchdog_expiry_reset && sleep_mode && !master_clear_pin_low;
  assign in_reset  = nxt_state != S_RUN;

  always_comb
  begin
    // Outputs follow the next state so they line up with state_ff
    nxt_core_reset = in_reset;
    // Only the resettable group sees this; retained ones stay unwired
    nxt_reg_reset  = in_reset;
    nxt_wake       = wdt_sleep && !supply_lost;
    nxt_cause      = cause_ff;
    if (supply_lost || state_ff == S_POWER_ON)
      nxt_cause = '{power_on: 1'h1, master_clear: 1'h0, watchdog: 1'h0};
    else if (state_ff == S_RUN && master_clear_pin_low)
      nxt_cause = '{power_on: 1'h0, master_clear: 1'h1, watchdog: 1'h0};
    else if (wdt_run)
      nxt_cause = '{power_on: 1'h0, master_clear: 1'h0, watchdog: 1'h1};
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      core_reset_ff <= 1'h1;
      reg_reset_ff  <= 1'h1;
      wake_pulse_ff <= 1'h0;
      cause_ff      <= '{power_on: 1'h1, master_clear: 1'h0, watchdog: 1'h0};
    end
    else
    begin
      core_reset_ff <= nxt_core_reset;
      reg_reset_ff  <= nxt_reg_reset;
      wake_pulse_ff <= nxt_wake;
      cause_ff      <= nxt_cause;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Timeout and powerdown flags

  status_flags_s nxt_flags;

  always_comb
  begin
    // Master clear falls through every branch: flags left unchanged
    nxt_flags = flags_ff;
    if (supply_lost || state_ff == S_POWER_ON)
    begin
      nxt_flags.timeout_flag   = TO_RST_VAL;
      nxt_flags.powerdown_flag = PD_RST_VAL;
    end
    else if (wdt_run)
    begin
      nxt_flags.timeout_flag   = 1'h0;
      nxt_flags.powerdown_flag = 1'h1;
    end
    else if (wdt_sleep)
    begin
      nxt_flags.timeout_flag   = 1'h0;
      nxt_flags.powerdown_flag = 1'h0;
    end
    else if (state_ff == S_RUN && !master_clear_pin_low && watchdog_clear)
    begin
      nxt_flags.timeout_flag   = 1'h1;
      nxt_flags.powerdown_flag = 1'h1;
    end
    else if (state_ff == S_RUN && !master_clear_pin_low && sleep_enter)
    begin
      nxt_flags.timeout_flag   = 1'h1;
      nxt_flags.powerdown_flag = 1'h0;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      flags_ff <= '{timeout_flag: TO_RST_VAL, powerdown_flag: PD_RST_VAL};
    else
      flags_ff <= nxt_flags;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Phase sequencer and bus strobe parking

  logic [3:0]  nxt_phase;
  bus_strobe_s nxt_bus_out;
  bus_strobe_s nxt_bus_oe;

  always_comb
  begin
    if (in_reset)
      nxt_phase = PHASE_FIRST;
    else
      nxt_phase = {phase_ff[2:0], phase_ff[3]};
    nxt_bus_out = core_bus_out;
    nxt_bus_oe  = core_bus_oe;
    // Parking keeps an external memory from seeing a stray cycle
    if (in_reset && ext_exec_mode)
    begin
      nxt_bus_out = '{ale: ALE_PARK, rd_n: RD_N_PARK, wr_n: WR_N_PARK};
      nxt_bus_oe  = '{ale: 1'h1, rd_n: 1'h1, wr_n: 1'h1};
    end
    else if (in_reset)
      nxt_bus_oe = '{ale: 1'h0, rd_n: 1'h0, wr_n: 1'h0};
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      phase_ff   <= PHASE_FIRST;
      bus_out_ff <= '{ale: ALE_PARK, rd_n: RD_N_PARK, wr_n: WR_N_PARK};
      bus_oe_ff  <= '{ale: 1'h0, rd_n: 1'h0, wr_n: 1'h0};
    end
    else
    begin
      phase_ff   <= nxt_phase;
      bus_out_ff <= nxt_bus_out;
      bus_oe_ff  <= nxt_bus_oe;
    end
  end

endmodule

`default_nettype wire

// ---- testbench/pin_supply_model.sv ----
// Model of the master clear pin, supply monitor and RC oscillator
`timescale 1ns/100ps
`default_nettype none
module pin_supply_model #(
  parameter realtime SKEW = 7.0
)(
  input  wire logic pin_hold_low,
  input  wire logic supply_cut,
  output logic      master_clear_pin_n,
  output logic      supply_above_trip,
  output logic      rc_osc_clk
);
  // Pins are asynchronous to the core, hence the skew off the clock edge
  assign #SKEW master_clear_pin_n = !pin_hold_low;
  assign #SKEW supply_above_trip = !supply_cut;
  initial rc_osc_clk = 1'h0;
  // Free-running, unrelated in phase to the system clock
  always #205 rc_osc_clk = !rc_osc_clk;
endmodule
`default_nettype wire

// ---- testbench/reset_and_powerup_sequencer_tb.sv ----
// Self-checking bench for the reset and power-up sequencer
`timescale 1ns/100ps
`default_nettype none
module reset_and_powerup_sequencer_tb;
  import reset_seq_pkg::*;
  localparam int unsigned TICKS = 4;
  logic          ref_clk = 1'h0;
  logic          rst = 1'h1;
  logic          pin_hold_low;
  logic          supply_cut;
  logic          watchdog_expiry_reset;
  logic          sleep_mode;
  logic          sleep_enter;
  logic          watchdog_clear;
  logic          ext_exec_mode;
  bus_strobe_s   core_bus_out;
  bus_strobe_s   core_bus_oe;
  logic          master_clear_pin_n, supply_above_trip, rc_osc_clk;
  logic          core_reset_ff, reg_reset_ff, wake_pulse_ff;
  logic [3:0]    phase_ff;
  status_flags_s flags_ff;
  reset_cause_s  cause_ff;
  bus_strobe_s   bus_out_ff, bus_oe_ff;
  logic [7:0]    exp_q[$];
  logic [7:0]    snap, last;
  int            bad_count = 0;
  int            n_checks = 0;
  always #25 ref_clk = !ref_clk;
  pin_supply_model u_model (.pin_hold_low, .supply_cut, .master_clear_pin_n,
    .supply_above_trip, .rc_osc_clk);
  reset_and_powerup_sequencer #(.POWER_UP_DELAY_TIMER_TICKS(TICKS), .FALLING_SUPPLY_RST(1'h1)) u_dut (
    .ref_clk, .rst, .master_clear_pin_n, .supply_above_trip, .rc_osc_clk,
    .watchdog_expiry_reset, .sleep_mode, .sleep_enter, .watchdog_clear, .ext_exec_mode,
    .core_bus_out, .core_bus_oe, .core_reset_ff, .reg_reset_ff, .wake_pulse_ff,
    .phase_ff, .flags_ff, .cause_ff, .bus_out_ff, .bus_oe_ff);
  ////////////////////////////////////////////////////////////
  task automatic check(string nm, logic [7:0] seen, logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic drain(int lim);
    repeat (lim) if (exp_q.size() != 0) @(posedge ref_clk);
    check("pending results", 8'(exp_q.size()), 8'h00);
  endtask
  // k: 0 watchdog, 1 sleep entry, 2 watchdog clear
  task automatic pulse(int k);
    @(posedge ref_clk) {watchdog_expiry_reset, sleep_enter, watchdog_clear} <= 3'h4 >> k;
    @(posedge ref_clk) {watchdog_expiry_reset, sleep_enter, watchdog_clear} <= 3'h0;
  endtask
  // Snapshot {reset, reg reset, wake, timeout, powerdown, cause}
  always @(posedge ref_clk)
  begin
    #1;
    snap = {core_reset_ff, reg_reset_ff, wake_pulse_ff, flags_ff, cause_ff};
    if (!rst && snap !== last)
      check("reset outputs", snap, exp_q.size() ? exp_q.pop_front() : 8'hXX);
    last = snap;
  end
  always @(posedge ref_clk)
  begin
    core_bus_out  <= bus_strobe_s'(3'($urandom));
    core_bus_oe   <= bus_strobe_s'(3'($urandom));
    ext_exec_mode <= 1'($urandom);
  end
  initial
  begin
    void'($urandom(10));
    // Idle levels are driven here so every input stays a live stimulus
    pin_hold_low          <= 1'h0;
    supply_cut            <= 1'h0;
    watchdog_expiry_reset <= 1'h0;
    sleep_mode            <= 1'h0;
    sleep_enter           <= 1'h0;
    watchdog_clear        <= 1'h0;
    ext_exec_mode         <= 1'h0;
    core_bus_out          <= bus_strobe_s'(3'h0);
    core_bus_oe           <= bus_strobe_s'(3'h0);
    repeat (16) @(posedge ref_clk);
    exp_q.push_back(8'h1C);
    rst <= 1'h0;
    drain(TICKS * 12 + 20);
    exp_q.push_back(8'hC9);
    exp_q.push_back(8'h09);
    pulse(0);
    drain(10);
    exp_q.push_back(8'h11);
    pulse(1);
    sleep_mode <= 1'h1;
    drain(5);
    exp_q.push_back(8'h21);
    exp_q.push_back(8'h01);
    pulse(0);
    drain(5);
    exp_q.push_back(8'hC2);
    exp_q.push_back(8'h02);
    @(posedge ref_clk) pin_hold_low <= 1'h1;
    repeat (4) @(posedge ref_clk);
    pulse(0);
    @(posedge ref_clk) pin_hold_low <= 1'h0;
    sleep_mode <= 1'h0;
    drain(10);
    exp_q.push_back(8'h1A);
    pulse(2);
    drain(5);
    exp_q.push_back(8'hDC);
    exp_q.push_back(8'h1C);
    @(posedge ref_clk) supply_cut <= 1'h1;
    repeat (6) @(posedge ref_clk);
    pulse(0);
    pulse(1);
    @(posedge ref_clk) supply_cut <= 1'h0;
    drain(TICKS * 12 + 20);
    tally_and_finish();
  end
  initial
  begin
    #(50 * 3000);
    bad_count++;
    tally_and_finish();
  end
endmodule
`default_nettype wire

// ---- testbench/reset_seq_asserts.sv ----
// Port-level checks for the reset and power-up sequencer
`timescale 1ns/100ps
`default_nettype none
module reset_seq_asserts
  import reset_seq_pkg::*;
#(
  parameter int unsigned POWER_UP_DELAY_TIMER_TICKS = POWER_UP_DELAY_TIMER_TICKS_DFLT
)(
  input wire logic          ref_clk,
  input wire logic          rst,
  input wire logic          master_clear_pin_n,
  input wire logic          supply_above_trip,
  input wire logic          rc_osc_clk,
  input wire logic          watchdog_expiry_reset,
  input wire logic          sleep_mode,
  input wire logic          ext_exec_mode,
  input wire logic          core_reset_ff,
  input wire logic          wake_pulse_ff,
  input wire logic [3:0]    phase_ff,
  input wire status_flags_s flags_ff,
  input wire reset_cause_s  cause_ff,
  input wire bus_strobe_s   bus_out_ff,
  input wire bus_strobe_s   bus_oe_ff
);
  logic [7:0] cnt_ff;
  logic [7:0] nxt_cnt;
  logic       rc_q_ff;
  // Raw oscillator edges, saturating at 8'hFF: below that this count never lags the synchronised one
  always_comb nxt_cnt = (rst || !master_clear_pin_n || !supply_above_trip) ? 8'h00 :
    cnt_ff + {7'h00, rc_osc_clk && !rc_q_ff && cnt_ff != 8'hFF};
  always_ff @(posedge ref_clk)
  begin
    cnt_ff  <= nxt_cnt;
    rc_q_ff <= rc_osc_clk;
  end
  ////////////////////////////////////////////////////////////
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Watchdog seen while running with the pin settled high
  sequence wd_run;
    !core_reset_ff && watchdog_expiry_reset && master_clear_pin_n &&
      $past(master_clear_pin_n, 2) && supply_above_trip;
  endsequence
  AST_PHASE_HOLD:
  assert property (core_reset_ff |-> phase_ff == PHASE_FIRST) else $error("phase moved");
  AST_PHASE_RUN:
  assert property (!core_reset_ff && !$past(core_reset_ff) && !$past(sleep_mode)
    |-> phase_ff == {$past(phase_ff[2:0]), $past(phase_ff[3])}) else $error("phase stuck");
  AST_STROBE_PARK:
  assert property (core_reset_ff && $past(ext_exec_mode) && !$past(rst) |->
    bus_out_ff == {ALE_PARK, RD_N_PARK, WR_N_PARK} && bus_oe_ff == 3'h7)
    else $error("strobes not parked");
  AST_PIN_RESET:
  assert property (!master_clear_pin_n [*3] |=> core_reset_ff) else $error("pin ignored");
  AST_SUPPLY_RESET:
  assert property (!supply_above_trip [*3] |=> core_reset_ff) else $error("supply ignored");
  AST_PIN_FLAGS:
  assert property ($rose(core_reset_ff) && cause_ff.master_clear |-> $stable(flags_ff))
    else $error("flags moved on pin reset");
  AST_WDT_AWAKE:
  assert property (wd_run ##0 !sleep_mode |=> core_reset_ff && cause_ff == 3'h1 &&
    flags_ff == 2'h1) else $error("watchdog reset wrong");
  AST_WDT_SLEEP:
  assert property (wd_run ##0 sleep_mode |=> wake_pulse_ff && !core_reset_ff &&
    flags_ff == 2'h0) else $error("sleep wake wrong");
  AST_RELEASE:
  assert property ($fell(core_reset_ff) |-> $past(master_clear_pin_n, 3) &&
    $past(supply_above_trip, 3)) else $error("early release");
  AST_POWER_UP_DELAY_TIMER_HOLD:
  assert property ($fell(core_reset_ff) && cause_ff.power_on |-> cnt_ff >= POWER_UP_DELAY_TIMER_TICKS)
    else $error("delay cut short");
  cover property (wake_pulse_ff);
  cover property ($rose(core_reset_ff) && cause_ff.watchdog);
  cover property ($fell(core_reset_ff) && cause_ff.master_clear);
endmodule
bind reset_and_powerup_sequencer reset_seq_asserts #(.POWER_UP_DELAY_TIMER_TICKS(POWER_UP_DELAY_TIMER_TICKS)) u_chk (
  .ref_clk, .rst, .master_clear_pin_n, .supply_above_trip, .rc_osc_clk,
  .watchdog_expiry_reset, .sleep_mode, .ext_exec_mode, .core_reset_ff, .wake_pulse_ff,
  .phase_ff, .flags_ff, .cause_ff, .bus_out_ff, .bus_oe_ff);
`default_nettype wire
